// [pkg/psfs_pkg.sv]
// constants for the sequencing, fault-response and summary-status registers
`default_nettype none
package psfs_pkg;
   // command codes
   localparam logic [7:0] CMD_RESP = 8'h63;
   localparam logic [7:0] CMD_DELAY = 8'h64;
   localparam logic [7:0] CMD_RAMP = 8'h65;
   localparam logic [7:0] CMD_SBYTE = 8'h78;
   localparam logic [7:0] CMD_SWORD = 8'h79;
   // reset values
   localparam logic [7:0] RESP_RST = 8'h80;
   localparam logic [15:0] DELAY_RST = 16'h0000;
   localparam logic [15:0] RAMP_RST = 16'h0005;
   // response field encodings
   localparam logic [1:0] ACT_CONT = 2'h0;
   localparam logic [1:0] ACT_OFF = 2'h2;
   localparam logic [2:0] RETRY_LATCH = 3'h0;
   localparam logic [2:0] RETRY_HICCUP = 3'h7;
   localparam logic [4:0] DELAY_MAX_MS = 5'h0A;
   localparam logic [4:0] RAMP_MAX_MS = 5'h14;
   // sticky fault vector positions
   localparam int F_VOUT_OV = 0;
   localparam int F_OC_PEAK = 1;
   localparam int F_TEMP = 2;
   localparam int F_VIN = 3;
   localparam int F_IOUT_OTH = 4;
   localparam int F_MFR = 5;
   localparam int F_HSLIM = 6;
   localparam int F_OTHER = 7;
   localparam int F_VOUT_OTH = 8;
   localparam int F_NUM = 9;
   // timing
   localparam int CLK_NS = 8;
   localparam int MS_NS = 1000000;
   localparam int HICCUP_MS = 1000;
   localparam int TON_MAX_MS = 12;
   localparam logic [27:0] MS_CYC = 28'(MS_NS / CLK_NS);
   localparam logic [27:0] HICCUP_CYC = 28'(HICCUP_MS * (MS_NS / CLK_NS));
   localparam logic [27:0] TON_MAX_CYC = 28'(TON_MAX_MS * (MS_NS / CLK_NS));
   typedef enum logic [2:0] {
      PS_OFF = 3'h0, PS_START = 3'h1, PS_ON = 3'h3, PS_STOP_DLY = 3'h2,
      PS_STOP_FALL = 3'h6, PS_HICCUP = 3'h7, PS_LATCH = 3'h5
   } psfs_pwr_t;
   typedef enum logic [3:0] {
      BS_IDLE = 4'h0, BS_ADDR = 4'h1, BS_ACK_A = 4'h3, BS_CMD = 4'h2, BS_ACK_C = 4'h6,
      BS_WDAT = 4'h7, BS_ACK_D = 4'h5, BS_RDAT = 4'h4, BS_RACK = 4'hC, BS_RWAIT = 4'hD
   } psfs_bus_t;
endpackage
`default_nettype wire

// [verilog/psfs_regs.sv]
// serial-bus command registers for startup fault response, stop timing and summary status
`default_nettype none
module psfs_regs
   import psfs_pkg::*;
#(
   parameter logic [6:0] DEV_ADDR = 7'h40, // arbitrary bus address
   parameter logic [27:0] MS_CYCLES = MS_CYC,
   parameter logic [27:0] HICCUP_CYCLES = HICCUP_CYC,
   parameter logic [27:0] TON_MAX_CYCLES = TON_MAX_CYC
) (
   input wire logic CLOCK_IN,
   input wire logic RST_N_IN,
   input wire logic SCL_IN,
   input wire logic SDA_IN,
   output logic SDA_OUT,
   output logic SDA_OE_OUT,
   output logic ALERT_N_OUT,
   input wire logic VOUT_OV_IN,
   input wire logic OC_PEAK_IN,
   input wire logic TEMP_IN,
   input wire logic VIN_FAULT_IN,
   input wire logic IOUT_OTHER_IN,
   input wire logic MFR_FAULT_IN,
   input wire logic HIGH_SIDE_CURRENT_LIMIT_FLAG_IN,
   input wire logic OTHER_FAULT_IN,
   input wire logic VOUT_OTHER_IN,
   input wire logic POWER_GOOD_IN,
   input wire logic NVM_BUSY_IN,
   input wire logic ENABLE_IN,
   input wire logic SUPPLY_OK_IN,
   input wire logic SHUTDOWN_FAULT_IN,
   input wire logic VOUT_ABOVE_UV_IN,
   input wire logic CLEAR_FAULTS_IN,
   output logic POWER_STAGE_ON_OUT,
   output logic RAMP_DOWN_OUT,
   output logic [7:0] RESP_VALUE_OUT,
   output logic [15:0] DELAY_VALUE_OUT,
   output logic [15:0] RAMP_VALUE_OUT
);
   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic logic [27:0] ms_cyc(input logic [4:0] ms, input logic [27:0] unit);
      return 28'(ms * unit);
   endfunction
   function automatic logic done(input logic [27:0] cnt, input logic [27:0] target);
      return ({1'b0, cnt} + 29'h1) >= {1'b0, target};
   endfunction
   function automatic logic resp_ok(input logic [7:0] d);
      return (d[7:6] == ACT_CONT || d[7:6] == ACT_OFF) &&
             (d[5:3] == RETRY_LATCH || d[5:3] == RETRY_HICCUP) && d[2:0] == 3'h0;
   endfunction
   function automatic logic delay_ok(input logic [15:0] d);
      return d[15:4] == 12'h000 && d[4:0] <= DELAY_MAX_MS;
   endfunction
   function automatic logic ramp_ok(input logic [15:0] d);
      return d[15:5] == 11'h000 && d[4:0] != 5'h00 && d[4:0] <= RAMP_MAX_MS;
   endfunction

   // ------------------------------------------------------------
   // input synchronisers
   // ------------------------------------------------------------
   logic [19:0] sm_r, ss_r;
   logic scl_d_r, sda_d_r;
   logic scl_s, sda_s, pg_s, busy_s, en_s, sup_s, shut_s, uv_s;
   logic [F_NUM-1:0] src;
   always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         sm_r <= 20'h00003;
         ss_r <= 20'h00003;
         scl_d_r <= 1'b1;
         sda_d_r <= 1'b1;
      end else begin
         sm_r <= {VOUT_OTHER_IN, OTHER_FAULT_IN, HIGH_SIDE_CURRENT_LIMIT_FLAG_IN, MFR_FAULT_IN,
                  IOUT_OTHER_IN, VIN_FAULT_IN, TEMP_IN, OC_PEAK_IN, VOUT_OV_IN, POWER_GOOD_IN,
                  NVM_BUSY_IN, ENABLE_IN, SUPPLY_OK_IN, SHUTDOWN_FAULT_IN, VOUT_ABOVE_UV_IN,
                  1'b0, 1'b0, 1'b0, SCL_IN, SDA_IN};
         ss_r <= sm_r;
         scl_d_r <= scl_s;
         sda_d_r <= sda_s;
      end
   end
   assign {src, pg_s, busy_s, en_s, sup_s, shut_s, uv_s} = ss_r[19:5];
   assign scl_s = ss_r[1];
   assign sda_s = ss_r[0];
   wire scl_rise = scl_s & ~scl_d_r;
   wire scl_fall = ~scl_s & scl_d_r;
   wire start = scl_s & scl_d_r & ~sda_s & sda_d_r;
   wire stop = scl_s & scl_d_r & sda_s & ~sda_d_r;

   // ------------------------------------------------------------
   // registers and status
   // ------------------------------------------------------------
   psfs_pwr_t pwr_r, pwr_nxt;
   logic [7:0] resp_r, resp_nxt;
   logic [15:0] delay_r, delay_nxt, ramp_r, ramp_nxt;
   logic [F_NUM-1:0] flt_r, flt_nxt;
   logic ton_r, ton_nxt, cml_r, cml_nxt;
   logic commit, bad_cmd, inval, ton_set;
   logic [7:0] cmd_r;
   logic [15:0] wd_r;
   logic [1:0] wn_r;
   logic [7:0] sbyte;
   logic [15:0] sword;
   wire off = !(pwr_r == PS_START || pwr_r == PS_ON || pwr_r == PS_STOP_DLY);
   // one status byte feeds both reads so they can never disagree
   // shared low byte
   assign sbyte = {busy_s, off, flt_r[F_VOUT_OV], flt_r[F_OC_PEAK], 1'b0, flt_r[F_TEMP], cml_r,
                   |{flt_r[F_VIN], flt_r[F_IOUT_OTH], flt_r[F_MFR], flt_r[F_HSLIM],
                     flt_r[F_OTHER]}};
   // upper summary, power good negated, low bits zero
   assign sword = {flt_r[F_VOUT_OV] | ton_r | flt_r[F_VOUT_OTH],
                   flt_r[F_OC_PEAK] | flt_r[F_IOUT_OTH], flt_r[F_VIN],
                   flt_r[F_MFR] | flt_r[F_HSLIM], ~pg_s, 3'h0, sbyte};

   always_comb begin
      resp_nxt = resp_r;
      delay_nxt = delay_r;
      ramp_nxt = ramp_r;
      inval = 1'b0;
      if (commit) begin
         case (cmd_r)
            CMD_RESP: begin
               if (wn_r == 2'h1 && resp_ok(wd_r[7:0])) resp_nxt = wd_r[7:0];
               else inval = 1'b1;
            end
            CMD_DELAY: begin
               if (wn_r == 2'h2 && delay_ok(wd_r)) delay_nxt = wd_r;
               else inval = 1'b1;
            end
            CMD_RAMP: begin
               if (wn_r == 2'h2 && ramp_ok(wd_r)) ramp_nxt = wd_r;
               else inval = 1'b1;
            end
            default: inval = 1'b0;
         endcase
      end
      flt_nxt = (flt_r & {F_NUM{~CLEAR_FAULTS_IN}}) | src;
      ton_nxt = (ton_r & ~CLEAR_FAULTS_IN) | ton_set;
      cml_nxt = (cml_r & ~CLEAR_FAULTS_IN) | inval | bad_cmd;
   end
   // values offered to the store logic
   always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         resp_r <= RESP_RST;
         delay_r <= DELAY_RST;
         ramp_r <= RAMP_RST;
         flt_r <= '0;
         ton_r <= 1'b0;
         cml_r <= 1'b0;
      end else begin
         resp_r <= resp_nxt;
         delay_r <= delay_nxt;
         ramp_r <= ramp_nxt;
         flt_r <= flt_nxt;
         ton_r <= ton_nxt;
         cml_r <= cml_nxt;
      end
   end
   assign ALERT_N_OUT = ~(|flt_r | ton_r | cml_r);
   assign RESP_VALUE_OUT = resp_r;
   assign DELAY_VALUE_OUT = delay_r;
   assign RAMP_VALUE_OUT = ramp_r;

   // ------------------------------------------------------------
   // power sequencing
   // ------------------------------------------------------------
   logic [27:0] cnt_r, cnt_nxt;
   wire run_ok = en_s & sup_s & ~shut_s;
   always_comb begin
      pwr_nxt = pwr_r;
      cnt_nxt = cnt_r + 28'h1;
      ton_set = 1'b0;
      case (pwr_r)
         PS_OFF: begin
            cnt_nxt = '0;
            if (run_ok) pwr_nxt = PS_START;
         end
         PS_START: begin
            if (!run_ok) pwr_nxt = PS_OFF;
            else if (uv_s) pwr_nxt = PS_ON;
            else if (done(cnt_r, TON_MAX_CYCLES)) begin
               ton_set = 1'b1;
               cnt_nxt = '0;
               if (resp_r[7:6] == ACT_CONT) pwr_nxt = PS_ON;
               else if (resp_r[5:3] == RETRY_HICCUP) pwr_nxt = PS_HICCUP;
               else pwr_nxt = PS_LATCH;
            end
         end
         PS_ON: begin
            cnt_nxt = '0;
            if (shut_s || !sup_s) pwr_nxt = PS_OFF;
            else if (!en_s) pwr_nxt = PS_STOP_DLY;
         end
         PS_STOP_DLY: begin
            if (done(cnt_r, ms_cyc(delay_r[4:0], MS_CYCLES))) begin
               pwr_nxt = PS_STOP_FALL;
               cnt_nxt = '0;
            end
         end
         PS_STOP_FALL: begin
            if (done(cnt_r, ms_cyc(ramp_r[4:0], MS_CYCLES))) pwr_nxt = PS_OFF;
         end
         PS_HICCUP: begin
            if (!run_ok) pwr_nxt = PS_OFF;
            else if (done(cnt_r, HICCUP_CYCLES)) begin
               pwr_nxt = PS_START;
               cnt_nxt = '0;
            end
         end
         PS_LATCH: begin
            cnt_nxt = '0;
            if (CLEAR_FAULTS_IN) pwr_nxt = PS_OFF;
         end
         default: pwr_nxt = PS_OFF;
      endcase
   end
   always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         pwr_r <= PS_OFF;
         cnt_r <= '0;
      end else begin
         pwr_r <= pwr_nxt;
         cnt_r <= cnt_nxt;
      end
   end
   assign POWER_STAGE_ON_OUT = ~off;
   assign RAMP_DOWN_OUT = (pwr_r == PS_STOP_FALL);

   // ------------------------------------------------------------
   // serial bus slave
   // ------------------------------------------------------------
   psfs_bus_t bs_r, bs_nxt;
   logic [7:0] sh_r, sh_nxt, cmd_nxt, rbyte;
   logic [2:0] bc_r, bc_nxt;
   logic [15:0] wd_nxt, rval;
   logic [1:0] wn_nxt, br_r, br_nxt;
   logic drv_r, drv_nxt, rd_r, rd_nxt;
   wire [7:0] inb = {sh_r[6:0], sda_s};
   always_comb begin
      case (cmd_r)
         CMD_RESP: rval = {8'h00, resp_r};
         CMD_DELAY: rval = delay_r;
         CMD_RAMP: rval = ramp_r;
         CMD_SBYTE: rval = {8'h00, sbyte};
         CMD_SWORD: rval = sword;
         default: rval = 16'h0000;
      endcase
      rbyte = (br_r == 2'h0) ? rval[7:0] : (br_r == 2'h1) ? rval[15:8] : 8'h00;
   end
   always_comb begin
      bs_nxt = bs_r;
      sh_nxt = sh_r;
      bc_nxt = bc_r;
      drv_nxt = drv_r;
      cmd_nxt = cmd_r;
      wd_nxt = wd_r;
      wn_nxt = wn_r;
      br_nxt = br_r;
      rd_nxt = rd_r;
      commit = 1'b0;
      bad_cmd = 1'b0;
      if (start) begin
         bs_nxt = BS_ADDR;
         bc_nxt = 3'h0;
         drv_nxt = 1'b0;
      end else if (stop) begin
         commit = (bs_r != BS_IDLE) && !rd_r && wn_r != 2'h0;
         bs_nxt = BS_IDLE;
         drv_nxt = 1'b0;
      end else begin
         case (bs_r)
            BS_ADDR: if (scl_rise) begin
               sh_nxt = inb;
               bc_nxt = bc_r + 3'h1;
               if (bc_r == 3'h7) begin
                  rd_nxt = sda_s;
                  bs_nxt = (sh_r[6:0] == DEV_ADDR) ? BS_ACK_A : BS_IDLE;
               end
            end
            BS_ACK_A: if (scl_fall) begin
               drv_nxt = ~drv_r;
               bc_nxt = 3'h0;
               if (drv_r && rd_r) begin
                  sh_nxt = rbyte;
                  br_nxt = 2'h1;
                  bs_nxt = BS_RDAT;
                  bad_cmd = (rval == 16'h0000) && !(cmd_r inside {CMD_RESP, CMD_DELAY,
                            CMD_RAMP, CMD_SBYTE, CMD_SWORD});
               end else if (drv_r) begin
                  wn_nxt = 2'h0;
                  br_nxt = 2'h0;
                  bs_nxt = BS_CMD;
               end
            end
            BS_CMD: if (scl_rise) begin
               sh_nxt = inb;
               bc_nxt = bc_r + 3'h1;
               if (bc_r == 3'h7) begin
                  cmd_nxt = inb;
                  bs_nxt = BS_ACK_C;
               end
            end
            BS_ACK_C, BS_ACK_D: if (scl_fall) begin
               drv_nxt = ~drv_r;
               bc_nxt = 3'h0;
               if (drv_r) bs_nxt = BS_WDAT;
            end
            BS_WDAT: if (scl_rise) begin
               sh_nxt = inb;
               bc_nxt = bc_r + 3'h1;
               if (bc_r == 3'h7) begin
                  if (wn_r == 2'h0) wd_nxt[7:0] = inb;
                  else if (wn_r == 2'h1) wd_nxt[15:8] = inb;
                  if (wn_r != 2'h3) wn_nxt = wn_r + 2'h1;
                  // writes to read-only or unknown codes count as bad commands
                  bad_cmd = !(cmd_r inside {CMD_RESP, CMD_DELAY, CMD_RAMP});
                  bs_nxt = BS_ACK_D;
               end
            end
            // last bit held until scl falls, else sda moves while scl is high
            BS_RDAT: begin
               if (scl_rise) bc_nxt = bc_r + 3'h1;
               else if (scl_fall && bc_r == 3'h0) bs_nxt = BS_RACK;
               else if (scl_fall) sh_nxt = {sh_r[6:0], 1'b1};
            end
            BS_RACK: if (scl_rise) bs_nxt = sda_s ? BS_IDLE : BS_RWAIT;
            BS_RWAIT: if (scl_fall) begin
               sh_nxt = rbyte;
               bc_nxt = 3'h0;
               if (br_r != 2'h3) br_nxt = br_r + 2'h1;
               bs_nxt = BS_RDAT;
            end
            default: bs_nxt = BS_IDLE;
         endcase
      end
   end
   always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         bs_r <= BS_IDLE;
         sh_r <= 8'hFF;
         bc_r <= 3'h0;
         drv_r <= 1'b0;
         cmd_r <= 8'h00;
         wd_r <= 16'h0000;
         wn_r <= 2'h0;
         br_r <= 2'h0;
         rd_r <= 1'b0;
      end else begin
         bs_r <= bs_nxt;
         sh_r <= sh_nxt;
         bc_r <= bc_nxt;
         drv_r <= drv_nxt;
         cmd_r <= cmd_nxt;
         wd_r <= wd_nxt;
         wn_r <= wn_nxt;
         br_r <= br_nxt;
         rd_r <= rd_nxt;
      end
   end
   // open drain: only ever pull low
   assign SDA_OUT = 1'b0;
   assign SDA_OE_OUT = drv_r | (bs_r == BS_RDAT && !sh_r[7]);

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge CLOCK_IN); endclocking
   default disable iff (!RST_N_IN);
   sequence s_ton_expire;
      pwr_r == PS_START && run_ok && !uv_s && done(cnt_r, TON_MAX_CYCLES);
   endsequence
   sequence s_stop_req;
      pwr_r == PS_ON && !en_s && sup_s && !shut_s;
   endsequence
   ton_flag_a: assert property (s_ton_expire |=> ton_r && sword[15])
      else $error("timeout did not set fault bits");
   alert_low_a: assert property (s_ton_expire |=> !ALERT_N_OUT)
      else $error("alert not asserted on timeout");
   sticky_flag_a: assert property (ton_r && !CLEAR_FAULTS_IN |=> ton_r)
      else $error("fault bit dropped without clear");
   latch_off_a: assert property (s_ton_expire ##0 (resp_r[7:6] == ACT_OFF &&
      resp_r[5:3] == RETRY_LATCH) |=> pwr_r == PS_LATCH [*2])
      else $error("latch-off not entered");
   hiccup_entry_a: assert property (s_ton_expire ##0 (resp_r[7:6] == ACT_OFF &&
      resp_r[5:3] == RETRY_HICCUP) |=> pwr_r == PS_HICCUP)
      else $error("hiccup not entered");
   resp_guard_a: assert property (commit && cmd_r == CMD_RESP && !resp_ok(wd_r[7:0])
      |=> $stable(resp_r) && cml_r)
      else $error("invalid response write accepted");
   delay_guard_a: assert property (commit && cmd_r == CMD_DELAY && wd_r[15:4] != 12'h000
      |=> $stable(delay_r) && cml_r)
      else $error("invalid stop delay accepted");
   ramp_guard_a: assert property (commit && cmd_r == CMD_RAMP && wd_r[4:0] == 5'h00
      |=> $stable(ramp_r) && cml_r)
      else $error("zero stop ramp accepted");
   stop_seq_a: assert property (s_stop_req |=>
      pwr_r == PS_STOP_DLY ##0 POWER_STAGE_ON_OUT)
      else $error("stop request did not start delay");
   pgood_bit_a: assert property ($fell(pg_s) |-> sword[11] && !sword[10])
      else $error("power good negated bit wrong");
endmodule
`default_nettype wire

// [testbench/psfs_host.sv]
// serial bus host model: start, stop, byte transfers, register write and read
`default_nettype none
module psfs_host #(
   parameter logic [6:0] ADDR = 7'h40
) (
   input wire logic clk_in,
   input wire logic sda_in,
   output logic scl_out,
   output logic sda_pull_out
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      scl_out = 1'b1;
      sda_pull_out = 1'b0;
   end
   task automatic tick(input int n);
      repeat (n) @(negedge clk_in);
   endtask
   // data moves only while scl is low; sampled mid high phase
   task automatic bit_cycle(input logic b, output logic s);
      sda_pull_out = ~b;
      tick(5);
      scl_out = 1'b1;
      tick(5);
      s = sda_in;
      tick(5);
      scl_out = 1'b0;
      tick(5);
   endtask
   // a=0,c=1 gives a (repeated) start, a=1,c=0 a stop
   task automatic frame(input logic a, input logic c);
      sda_pull_out = a;
      tick(5);
      scl_out = 1'b1;
      tick(5);
      sda_pull_out = c;
      tick(5);
      scl_out = ~c;
      tick(5);
   endtask
   // chk: the device must pull the acknowledge bit low
   task automatic xfer(input logic [7:0] v, input logic ack_v, input logic chk,
                       output logic [7:0] r, inout logic ok);
      logic a;
      for (int i = 7; i >= 0; i--) bit_cycle(v[i], r[i]);
      bit_cycle(ack_v, a);
      ok = ok & (~chk | ~a);
   endtask
   task automatic wr(input logic [7:0] cmd, input int n, input logic [15:0] d,
                     output logic ok);
      logic [7:0] r;
      ok = 1'b1;
      frame(1'b0, 1'b1);
      xfer({ADDR, 1'b0}, 1'b1, 1'b1, r, ok);
      xfer(cmd, 1'b1, 1'b1, r, ok);
      for (int i = 0; i < n; i++) xfer(d[8*i+:8], 1'b1, 1'b1, r, ok);
      frame(1'b1, 1'b0);
   endtask
   // last byte is refused by the host so the device lets go of the line
   task automatic rd(input logic [7:0] cmd, input int n, output logic [15:0] d,
                     output logic ok);
      logic [7:0] r;
      ok = 1'b1;
      d = 16'h0000;
      frame(1'b0, 1'b1);
      xfer({ADDR, 1'b0}, 1'b1, 1'b1, r, ok);
      xfer(cmd, 1'b1, 1'b1, r, ok);
      frame(1'b0, 1'b1);
      xfer({ADDR, 1'b1}, 1'b1, 1'b1, r, ok);
      for (int i = 0; i < n; i++) begin
         xfer(8'hFF, i == n - 1, 1'b0, r, ok);
         d[8*i+:8] = r;
      end
      frame(1'b1, 1'b0);
   endtask
endmodule
`default_nettype wire

// [testbench/psfs_regs_bench.sv]
// self-checking bench: register access, fault summary and power sequencing
`default_nettype none
module psfs_regs_bench
   import psfs_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;
   logic clock_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic [8:0] flt = 9'h000;
   logic power_good = 1'b1;
   logic nvm_busy = 1'b0;
   logic enable = 1'b0;
   logic clear_flt = 1'b0;
   logic vout_uv = 1'b0;
   logic supply_ok = 1'b1;
   logic scl, sda_pull, sda_oe, sda_o, alert_n, stage_on, ramp_dn, ok;
   logic [7:0] resp_val;
   logic [15:0] delay_val, ramp_val, rdat, keep;
   int errors = 0;
   int checks_done = 0;
   int n;
   wire logic sda_line = ~(sda_pull | (sda_oe & ~sda_o));
   // expected status word per sticky fault position
   logic [15:0] fexp [9] = '{16'h8060, 16'h4050, 16'h0044, 16'h2041, 16'h4041, 16'h1041,
                             16'h1041, 16'h0041, 16'h8040};
   logic [7:0] vc [7] = '{CMD_RESP, CMD_RESP, CMD_DELAY, CMD_RAMP, CMD_DELAY, CMD_RAMP,
                          CMD_RESP};
   logic [15:0] vd [7] = '{16'h0000, 16'h00B8, 16'h0000, 16'h0001, 16'h000A, 16'h0014,
                           16'h0080};
   logic [7:0] bc [10] = '{CMD_DELAY, CMD_DELAY, CMD_RAMP, CMD_RAMP, CMD_RAMP, CMD_RESP,
                           CMD_RESP, CMD_RESP, CMD_RESP, CMD_RESP};
   logic [15:0] bd [10] = '{16'h0800, 16'h0010, 16'h0800, 16'h0020, 16'h0000, 16'h0040,
                            16'h00C0, 16'h0088, 16'h0081, 16'h00B0};
   initial begin
      forever #4 clock_in = ~clock_in;
   end
   psfs_regs #(
      .MS_CYCLES(28'h000000A), .HICCUP_CYCLES(28'h00000C8), .TON_MAX_CYCLES(28'h0000064)
   ) i_dut (
      .CLOCK_IN(clock_in), .RST_N_IN(rst_n_in), .SCL_IN(scl), .SDA_IN(sda_line),
      .SDA_OUT(sda_o), .SDA_OE_OUT(sda_oe), .ALERT_N_OUT(alert_n),
      .VOUT_OV_IN(flt[F_VOUT_OV]), .OC_PEAK_IN(flt[F_OC_PEAK]), .TEMP_IN(flt[F_TEMP]),
      .VIN_FAULT_IN(flt[F_VIN]), .IOUT_OTHER_IN(flt[F_IOUT_OTH]), .MFR_FAULT_IN(flt[F_MFR]),
      .HIGH_SIDE_CURRENT_LIMIT_FLAG_IN(flt[F_HSLIM]), .OTHER_FAULT_IN(flt[F_OTHER]),
      .VOUT_OTHER_IN(flt[F_VOUT_OTH]), .POWER_GOOD_IN(power_good), .NVM_BUSY_IN(nvm_busy),
      .ENABLE_IN(enable), .SUPPLY_OK_IN(supply_ok), .SHUTDOWN_FAULT_IN(1'b0),
      .VOUT_ABOVE_UV_IN(vout_uv), .CLEAR_FAULTS_IN(clear_flt), .POWER_STAGE_ON_OUT(stage_on),
      .RAMP_DOWN_OUT(ramp_dn), .RESP_VALUE_OUT(resp_val), .DELAY_VALUE_OUT(delay_val),
      .RAMP_VALUE_OUT(ramp_val)
   );
   psfs_host i_host (.clk_in(clock_in), .sda_in(sda_line), .scl_out(scl),
                     .sda_pull_out(sda_pull));
   // ---------------------------------
   // checking and bus helpers
   // ---------------------------------
   task automatic complete_run();
      $display("checks_done %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
      checks_done++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic cmp_bit(input string what, input logic exp, input logic got);
      cmp(what, {15'h0, exp}, {15'h0, got});
   endtask
   function automatic int nb(input logic [7:0] c);
      return (c == CMD_DELAY || c == CMD_RAMP || c == CMD_SWORD) ? 2 : 1;
   endfunction
   function automatic logic [15:0] reg_of(input logic [7:0] c);
      if (c == CMD_RESP) return {8'h00, resp_val};
      if (c == CMD_DELAY) return delay_val;
      return ramp_val;
   endfunction
   task automatic wr(input logic [7:0] c, input logic [15:0] d);
      i_host.wr(c, nb(c), d, ok);
      cmp_bit("write ack", 1'b1, ok);
   endtask
   task automatic rd(input logic [7:0] c, output logic [15:0] d);
      i_host.rd(c, nb(c), d, ok);
      cmp_bit("read ack", 1'b1, ok);
   endtask
   task automatic clear();
      clear_flt = 1'b1;
      @(negedge clock_in);
      clear_flt = 1'b0;
      repeat (4) @(negedge clock_in);
   endtask
   // clocks a level lasts; bounded so a stuck output cannot hang the run
   task automatic span(input logic v, input logic on_sel, input int lim, output int k);
      k = 0;
      while ((on_sel ? stage_on : ramp_dn) === v && k < lim) begin
         @(negedge clock_in);
         k++;
      end
   endtask
   initial begin
      #700us;
      errors++;
      complete_run();
   end
   // ---------------------------------
   // scenarios
   // ---------------------------------
   initial begin
      repeat (8) @(negedge clock_in);
      rst_n_in = 1'b1;
      repeat (4) @(negedge clock_in);
      cmp("resp reset", 16'h0080, {8'h00, resp_val}); // default
      cmp("delay reset", 16'h0000, delay_val); // default
      cmp("ramp reset", 16'h0005, ramp_val); // default
      rd(CMD_RESP, rdat);
      cmp("resp read", 16'h0080, rdat); // default
      rd(CMD_SWORD, rdat);
      cmp("word idle", 16'h0040, rdat); // idle word
      power_good = 1'b0;
      nvm_busy = 1'b1;
      rd(CMD_SWORD, rdat);
      cmp("pg and busy", 16'h08C0, rdat); // live bits
      power_good = 1'b1;
      nvm_busy = 1'b0;
      for (int i = 0; i < 7; i++) begin
         wr(vc[i], vd[i]);
         cmp("stored", vd[i], reg_of(vc[i])); // stored value
         rd(vc[i], rdat);
         cmp("read back", vd[i], rdat); // read back
      end
      rd(CMD_SBYTE, rdat);
      cmp("no comms fault", 16'h0040, rdat); // clean
      rd(8'h70, rdat);
      cmp("unmapped read", 16'h0000, rdat); // zero data
      rd(CMD_SBYTE, rdat);
      cmp("unmapped flag", 16'h0042, rdat); // comms bit
      for (int i = 0; i < 10; i++) begin
         clear();
         keep = reg_of(bc[i]);
         wr(bc[i], bd[i]);
         cmp("unchanged", keep, reg_of(bc[i])); // kept
         rd(CMD_SBYTE, rdat);
         cmp("invalid flag", 16'h0042, rdat); // flagged
      end
      for (int i = 0; i < F_NUM; i++) begin
         clear();
         cmp_bit("alert idle", 1'b1, alert_n); // cleared
         flt[i] = 1'b1;
         repeat (6) @(negedge clock_in);
         flt[i] = 1'b0;
         repeat (6) @(negedge clock_in);
         rd(CMD_SWORD, rdat);
         cmp("word fault", fexp[i], rdat); // sticky summary
         rd(CMD_SBYTE, rdat);
         cmp("byte same", {8'h00, fexp[i][7:0]}, rdat); // shared byte
      end
      clear();
      enable = 1'b1;
      repeat (96) @(negedge clock_in);
      cmp_bit("start held", 1'b1, stage_on); // not early
      repeat (16) @(negedge clock_in);
      cmp_bit("timeout off", 1'b0, stage_on); // shutdown
      repeat (400) @(negedge clock_in);
      cmp_bit("latched off", 1'b0, stage_on); // no restart
      cmp_bit("alert ton", 1'b0, alert_n); // alert
      rd(CMD_SWORD, rdat);
      cmp("ton summary", 16'h8040, rdat); // summary
      wr(CMD_RESP, 16'h00B8);
      clear();
      repeat (20) @(negedge clock_in);
      span(1'b1, 1'b1, 200, n);
      span(1'b0, 1'b1, 400, n);
      cmp_bit("hiccup span", 1'b1, n > 197 && n < 204); // hiccup time
      repeat (120) @(negedge clock_in);
      enable = 1'b0;
      repeat (250) @(negedge clock_in);
      cmp_bit("retry stopped", 1'b0, stage_on); // stops on disable
      wr(CMD_RESP, 16'h0000);
      clear();
      enable = 1'b1;
      repeat (150) @(negedge clock_in);
      cmp_bit("continues", 1'b1, stage_on); // keeps running
      cmp_bit("alert cont", 1'b0, alert_n); // still flagged
      enable = 1'b0;
      span(1'b1, 1'b1, 300, n);
      cmp_bit("stop delay", 1'b1, n > 99 && n < 106); // delay time
      cmp_bit("ramp starts", 1'b1, ramp_dn); // ramp follows
      span(1'b1, 1'b0, 400, n);
      cmp_bit("ramp span", 1'b1, n > 197 && n < 204); // ramp time
      clear();
      vout_uv = 1'b1;
      enable = 1'b1;
      repeat (150) @(negedge clock_in);
      cmp_bit("uv reached", 1'b1, stage_on); // no timeout
      cmp_bit("alert uv", 1'b1, alert_n); // no fault
      supply_ok = 1'b0;
      repeat (6) @(negedge clock_in);
      cmp_bit("supply lost", 1'b0, stage_on); // supply loss
      complete_run();
   end
endmodule
`default_nettype wire
